// *** rtl/dpgr_hpd_capture.sv ***
`timescale 1ns/1ns
module dpgr_hpd_capture
  import dpgr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // events from the hot-plug detector and the status-read clear
  input wire logic hpd_long_i,
  input wire logic hpd_short_i,
  input wire logic clear_i,
  // captured event
  output logic [1:0] event_o
);
  logic [1:0] ev_q;
  logic [1:0] ev_d;

  // a new event wins over a clear in the same cycle; long over short
  always_comb begin
    ev_d = ev_q;
    if (clear_i) begin
      ev_d = EV_NONE;
    end
    if (hpd_long_i) begin
      ev_d = EV_LONG;
    end else if (hpd_short_i) begin
      ev_d = EV_SHORT;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_q <= EV_NONE;
    end else begin
      ev_q <= ev_d;
    end
  end

  assign event_o = ev_q;
endmodule : dpgr_hpd_capture

// *** rtl/dpgr_pattern_decode.sv ***
`timescale 1ns/1ns
module dpgr_pattern_decode
  import dpgr_pkg::*;
(
  // control fields
  input wire logic [3:0] pattern_select_i,
  input wire logic [4:0] lane_count_i,
  // decoded selection
  output dpgr_pat_t pattern_o,
  output logic [3:0] lane_enable_o,
  output logic lanes_zero_o
);
  always_comb begin
    case (pattern_select_i)
      PAT_VIDEO: pattern_o = DPGR_P_VIDEO;
      PAT_TP1, PAT_D102: pattern_o = DPGR_P_TP1;
      PAT_TP2: pattern_o = DPGR_P_TP2;
      PAT_TP3: pattern_o = DPGR_P_TP3;
      PAT_TP4: pattern_o = DPGR_P_TP4;
      PAT_IDLE: pattern_o = DPGR_P_IDLE;
      PAT_SER: pattern_o = DPGR_P_SER;
      PAT_PRBS7: pattern_o = DPGR_P_PRBS7;
      PAT_CUSTOM: pattern_o = DPGR_P_CUSTOM;
      PAT_COMPL: pattern_o = DPGR_P_COMPL;
      default: pattern_o = DPGR_P_INVALID;
    endcase
  end

  always_comb begin
    lanes_zero_o = (lane_count_i == LANES_OFF);
    case (lane_count_i)
      5'b0_0001: lane_enable_o = 4'h1;
      5'b0_0010: lane_enable_o = 4'h3;
      5'b0_0100: lane_enable_o = 4'hf;
      default: lane_enable_o = 4'h0;
    endcase
  end
endmodule : dpgr_pattern_decode

// *** rtl/dpgr_pkg.sv ***
package dpgr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h00;
  localparam logic [7:0] STAT_IDX = 8'h01;
  localparam logic [7:0] ISTAT_IDX = 8'h02;
  localparam logic [7:0] IMASK_IDX = 8'h03;
  localparam logic [7:0] AUXCMD_IDX = 8'h04;
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [9:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [9:0] ISTAT_ADDR = {ISTAT_IDX, 2'b00};
  localparam logic [9:0] IMASK_ADDR = {IMASK_IDX, 2'b00};
  localparam logic [9:0] AUXCMD_ADDR = {AUXCMD_IDX, 2'b00};
  // control fields
  localparam int HPD_EN_BIT = 31;
  localparam int AUX_EN_BIT = 30;
  localparam int RATE_HI = 28;
  localparam int RATE_LO = 21;
  localparam int ENH_BIT = 19;
  localparam int LANE_HI = 9;
  localparam int LANE_LO = 5;
  localparam int PAT_HI = 3;
  localparam int PAT_LO = 0;
  localparam logic [31:0] CTRL_WMASK = 32'hdfe8_03ef;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status fields
  localparam int LEVEL_BIT = 2;
  localparam logic [1:0] EV_NONE = 2'b00;
  localparam logic [1:0] EV_LONG = 2'b01;
  localparam logic [1:0] EV_SHORT = 2'b10;
  // own event status bits
  localparam int IS_AUX = 0;
  localparam int IS_HPD = 1;
  localparam logic [1:0] IS_RESET = 2'b00;
  // codes
  localparam logic [4:0] LANES_OFF = 5'b0_0000;
  localparam logic [3:0] PAT_VIDEO = 4'h0;
  localparam logic [3:0] PAT_TP1 = 4'h1;
  localparam logic [3:0] PAT_TP2 = 4'h2;
  localparam logic [3:0] PAT_TP3 = 4'h3;
  localparam logic [3:0] PAT_TP4 = 4'h7;
  localparam logic [3:0] PAT_IDLE = 4'h4;
  localparam logic [3:0] PAT_D102 = 4'h9;
  localparam logic [3:0] PAT_SER = 4'ha;
  localparam logic [3:0] PAT_PRBS7 = 4'hb;
  localparam logic [3:0] PAT_CUSTOM = 4'hc;
  localparam logic [3:0] PAT_COMPL = 4'hd;
  typedef enum logic [3:0] {
    DPGR_P_VIDEO, DPGR_P_TP1, DPGR_P_TP2, DPGR_P_TP3, DPGR_P_TP4,
    DPGR_P_IDLE, DPGR_P_SER, DPGR_P_PRBS7, DPGR_P_CUSTOM, DPGR_P_COMPL,
    DPGR_P_INVALID
  } dpgr_pat_t;
endpackage : dpgr_pkg

// *** rtl/dpgr_regs.sv ***
`timescale 1ns/1ns
// Function
// - aux enable and message ready raise irq
// - aux irq drops on disable or command read
// - hpd enable and new event raise irq
// - status read clears hpd irq and code
// - status code reports the causing event
// - lane count one two four; zero sends zero
// - rate field in 270 Mbps units drives reconfig
// - bit 19 selects enhanced framing
// - pattern field selects training and video patterns
// - pattern field selects test patterns too
// - event code 00 none 01 long 10 short
module dpgr_regs
  import dpgr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [9:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // aux channel side
  input wire logic aux_message_ready_i,
  input wire logic [31:0] aux_command_i,
  // hot-plug side
  input wire logic hpd_level_i,
  input wire logic hpd_long_i,
  input wire logic hpd_short_i,
  // main link control
  output logic [7:0] tx_reconfig_rate_o,
  output logic [3:0] lane_enable_o,
  output logic lanes_zero_o,
  output logic enhanced_frame_o,
  output logic [3:0] pattern_select_o,
  output dpgr_pat_t pattern_o,
  // interrupt
  output logic irq_o
);
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [1:0] ist_q;
  logic [1:0] ist_d;
  logic [1:0] imask_q;
  logic [1:0] imask_d;
  logic aux_irq_q;
  logic aux_irq_d;
  logic hpd_irq_q;
  logic hpd_irq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] hpd_event;
  logic hpd_new;
  logic aux_new;
  logic msg_q;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction : hit

  logic stat_rd;
  logic cmd_rd;
  assign stat_rd = rd_i && hit(addr_i, STAT_ADDR);
  assign cmd_rd = rd_i && hit(addr_i, AUXCMD_ADDR);
  assign hpd_new = hpd_long_i || hpd_short_i;
  assign aux_new = aux_message_ready_i && !msg_q;

  dpgr_hpd_capture u_hpd (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .hpd_long_i(hpd_long_i),
    .hpd_short_i(hpd_short_i),
    .clear_i(stat_rd),
    .event_o(hpd_event)
  );

  dpgr_pattern_decode u_dec (
    .pattern_select_i(ctrl_q[PAT_HI:PAT_LO]),
    .lane_count_i(ctrl_q[LANE_HI:LANE_LO]),
    .pattern_o(pattern_o),
    .lane_enable_o(lane_enable_o),
    .lanes_zero_o(lanes_zero_o)
  );

  // control and interrupt state
  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ist_d = ist_q;
    if (wr_i && hit(addr_i, CTRL_ADDR)) begin
      ctrl_d = wdata_i & CTRL_WMASK;
    end
    if (wr_i && hit(addr_i, IMASK_ADDR)) begin
      imask_d = wdata_i[1:0];
    end
    if (wr_i && hit(addr_i, ISTAT_ADDR)) begin
      ist_d = ist_q & ~wdata_i[1:0];
    end
    // set wins over write-one-to-clear
    if (aux_new) begin
      ist_d[IS_AUX] = 1'b1;
    end
    if (hpd_new) begin
      ist_d[IS_HPD] = 1'b1;
    end
    // aux interrupt sets on a rising message ready and holds until command read
    aux_irq_d = aux_irq_q;
    if (cmd_rd) begin
      aux_irq_d = 1'b0;
    end
    if (aux_new) begin
      aux_irq_d = 1'b1;
    end
    hpd_irq_d = hpd_irq_q;
    if (stat_rd) begin
      hpd_irq_d = 1'b0;
    end
    if (hpd_new) begin
      hpd_irq_d = 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        CTRL_ADDR: rdata_d = ctrl_q;
        STAT_ADDR: rdata_d = {29'h0000_0000, hpd_level_i, hpd_event};
        ISTAT_ADDR: rdata_d = {30'h0000_0000, ist_q};
        IMASK_ADDR: rdata_d = {30'h0000_0000, imask_q};
        AUXCMD_ADDR: rdata_d = aux_command_i;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= CTRL_RESET;
      imask_q <= IS_RESET;
      ist_q <= IS_RESET;
      aux_irq_q <= 1'b0;
      hpd_irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      msg_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      aux_irq_q <= aux_irq_d;
      hpd_irq_q <= hpd_irq_d;
      rdata_q <= rdata_d;
      msg_q <= aux_message_ready_i;
    end
  end

  assign rdata_o = rdata_q;
  assign tx_reconfig_rate_o = ctrl_q[RATE_HI:RATE_LO];
  assign enhanced_frame_o = ctrl_q[ENH_BIT];
  assign pattern_select_o = ctrl_q[PAT_HI:PAT_LO];
  // enable bits gate the aux and hpd causes; the masked status term ist_q & imask_q is not gated and holds the irq
  assign irq_o = (ctrl_q[AUX_EN_BIT] && aux_irq_q && aux_message_ready_i)
    || (ctrl_q[HPD_EN_BIT] && hpd_irq_q)
    || |(ist_q & imask_q);

  // a fresh aux reply latches and shows on the line while enabled
  property p_aux_irq;
    @(posedge ref_clk_i) disable iff (reset_i)
    aux_new |=> aux_irq_q
      && (irq_o || !ctrl_q[AUX_EN_BIT] || !aux_message_ready_i);
  endproperty
  a_aux_irq: assert property (p_aux_irq)
    else $error("aux irq missing");

  property p_aux_drop;
    @(posedge ref_clk_i) disable iff (reset_i)
    cmd_rd && !aux_new |=> !aux_irq_q;
  endproperty
  a_aux_drop: assert property (p_aux_drop)
    else $error("aux irq not dropped by command read");

  property p_aux_dis;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_i && hit(addr_i, CTRL_ADDR) && !wdata_i[AUX_EN_BIT]
      |=> !ctrl_q[AUX_EN_BIT];
  endproperty
  a_aux_dis: assert property (p_aux_dis)
    else $error("aux enable not cleared");

  property p_hpd_set;
    @(posedge ref_clk_i) disable iff (reset_i)
    hpd_new |=> hpd_irq_q && hpd_event != EV_NONE;
  endproperty
  a_hpd_set: assert property (p_hpd_set)
    else $error("hpd event not captured");

  property p_hpd_line;
    @(posedge ref_clk_i) disable iff (reset_i)
    hpd_new && ctrl_q[HPD_EN_BIT] && !(wr_i && hit(addr_i, CTRL_ADDR))
      |=> irq_o;
  endproperty
  a_hpd_line: assert property (p_hpd_line)
    else $error("hpd irq missing");

  property p_stat_clr;
    @(posedge ref_clk_i) disable iff (reset_i)
    stat_rd && !hpd_new |=> !hpd_irq_q && hpd_event == EV_NONE;
  endproperty
  a_stat_clr: assert property (p_stat_clr)
    else $error("status read did not clear");

  property p_stat_rd;
    @(posedge ref_clk_i) disable iff (reset_i)
    stat_rd |=> rdata_o[1:0] == $past(hpd_event);
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("status read lost event code");

  property p_lanes;
    @(posedge ref_clk_i) disable iff (reset_i)
    ctrl_q[LANE_HI:LANE_LO] == LANES_OFF
      |-> lanes_zero_o && lane_enable_o == 4'h0;
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("zero lane count not forced");

  property p_four;
    @(posedge ref_clk_i) disable iff (reset_i)
    ctrl_q[LANE_HI:LANE_LO] == 5'b0_0100 |-> lane_enable_o == 4'hf;
  endproperty
  a_four: assert property (p_four)
    else $error("four lanes not enabled");

  property p_rate;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_i && hit(addr_i, CTRL_ADDR)
      |=> tx_reconfig_rate_o == $past(wdata_i[RATE_HI:RATE_LO]);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate not driven");

  property p_frame;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_i && hit(addr_i, CTRL_ADDR)
      |=> enhanced_frame_o == $past(wdata_i[ENH_BIT]);
  endproperty
  a_frame: assert property (p_frame)
    else $error("framing bit wrong");

  property p_d102;
    @(posedge ref_clk_i) disable iff (reset_i)
    pattern_select_o == PAT_D102 |-> pattern_o == DPGR_P_TP1;
  endproperty
  a_d102: assert property (p_d102)
    else $error("test pattern decode wrong");

  property p_pat;
    @(posedge ref_clk_i) disable iff (reset_i)
    pattern_select_o == PAT_PRBS7 |-> pattern_o == DPGR_P_PRBS7;
  endproperty
  a_pat: assert property (p_pat)
    else $error("pattern decode wrong");

  property p_code;
    @(posedge ref_clk_i) disable iff (reset_i)
    hpd_long_i |=> hpd_event == EV_LONG;
  endproperty
  a_code: assert property (p_code)
    else $error("long event code wrong");

  property p_short;
    @(posedge ref_clk_i) disable iff (reset_i)
    hpd_short_i && !hpd_long_i |=> hpd_event == EV_SHORT;
  endproperty
  a_short: assert property (p_short)
    else $error("short event code wrong");

  property p_code_rsv;
    @(posedge ref_clk_i) disable iff (reset_i)
    hpd_event != 2'b11;
  endproperty
  a_code_rsv: assert property (p_code_rsv)
    else $error("reserved event code shown");

  property p_rsv;
    @(posedge ref_clk_i) disable iff (reset_i)
    (ctrl_q & ~CTRL_WMASK) == 32'h0000_0000;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved control bits set");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (reset_i)
    rd_i && addr_i[9:5] != 5'h00 |=> rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_idle;
    @(posedge ref_clk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data without a read");
endmodule : dpgr_regs

// *** testbench/dpgr_ctrl_model.sv ***
`timescale 1ns/1ns
// register master standing in for the policy-making controller
module dpgr_ctrl_model (
  // clock
  input wire logic ref_clk_i,
  // register port toward the block
  output logic [9:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i
);
  initial begin
    addr_o = 10'h000;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released lines show inverted values so nothing stale looks valid
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd_reg
endmodule : dpgr_ctrl_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
module tb;
  import dpgr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] addr;
  logic [31:0] wdata, rdata, r;
  logic wr, rd, ready, level, ev_long, ev_short;
  logic [31:0] aux_cmd = 32'h1234_5678;
  logic [7:0] rate;
  logic [3:0] lane_en, pat_sel;
  logic lanes_zero, enh, irq;
  dpgr_pat_t pat;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  dpgr_ctrl_model cpu (.ref_clk_i(ref_clk_i), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  dpgr_regs dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .aux_message_ready_i(ready), .aux_command_i(aux_cmd),
    .hpd_level_i(level), .hpd_long_i(ev_long), .hpd_short_i(ev_short),
    .tx_reconfig_rate_o(rate), .lane_enable_o(lane_en),
    .lanes_zero_o(lanes_zero), .enhanced_frame_o(enh),
    .pattern_select_o(pat_sel), .pattern_o(pat), .irq_o(irq));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic hpd_pulse(input logic lg, input logic sh);
    @(posedge ref_clk_i);
    ev_long <= lg;
    ev_short <= sh;
    @(posedge ref_clk_i);
    ev_long <= 1'b0;
    ev_short <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : hpd_pulse

  task automatic set_ready(input logic v);
    @(posedge ref_clk_i);
    ready <= v;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : set_ready

  task automatic s_reset();
    cpu.rd_reg(CTRL_ADDR, r);
    check(r, 32'h0000_0000);
    cpu.rd_reg(STAT_ADDR, r);
    check(r, 32'h0000_0004);
    check({31'h0, irq}, 32'h0000_0000);
  endtask : s_reset

  task automatic s_fields();
    logic [7:0] rt[4] = '{8'h06, 8'h0a, 8'h14, 8'h0e};
    logic [4:0] ln[4] = '{5'h01, 5'h02, 5'h04, 5'h00};
    logic [3:0] le[4] = '{4'h1, 4'h3, 4'hf, 4'h0};
    logic [3:0] pc[12] = '{PAT_VIDEO, PAT_TP1, PAT_TP2, PAT_TP3, PAT_TP4,
      PAT_IDLE, PAT_D102, PAT_SER, PAT_PRBS7, PAT_CUSTOM, PAT_COMPL, 4'h5};
    dpgr_pat_t pe[12] = '{DPGR_P_VIDEO, DPGR_P_TP1, DPGR_P_TP2, DPGR_P_TP3,
      DPGR_P_TP4, DPGR_P_IDLE, DPGR_P_TP1, DPGR_P_SER, DPGR_P_PRBS7,
      DPGR_P_CUSTOM, DPGR_P_COMPL, DPGR_P_INVALID};
    for (int i = 0; i < 4; i++) begin
      cpu.wr_reg(CTRL_ADDR, {3'h0, rt[i], 1'b0, i[0], 9'h0, ln[i], 5'h0});
      check({24'h0, rate}, {24'h0, rt[i]});
      check({31'h0, enh}, {31'h0, i[0]});
      check({28'h0, lane_en}, {28'h0, le[i]});
      check({31'h0, lanes_zero}, {31'h0, i == 3});
    end
    for (int i = 0; i < 12; i++) begin
      cpu.wr_reg(CTRL_ADDR, {28'h0, pc[i]});
      check({28'h0, pat_sel}, {28'h0, pc[i]});
      check({28'h0, pat}, {28'h0, pe[i]});
    end
    cpu.wr_reg(CTRL_ADDR, 32'hffff_ffff);
    cpu.rd_reg(CTRL_ADDR, r);
    check(r, 32'hdfe8_03ef);
    cpu.wr_reg(10'h3fc, 32'hffff_ffff);
    cpu.rd_reg(10'h3fc, r);
    check(r, 32'h0000_0000);
    cpu.wr_reg(CTRL_ADDR, 32'h0000_0000);
  endtask : s_fields

  task automatic s_aux();
    cpu.wr_reg(CTRL_ADDR, 32'h4000_0000);
    set_ready(1'b1);
    check({31'h0, irq}, 32'h0000_0001);
    cpu.rd_reg(AUXCMD_ADDR, r);
    check(r, 32'h1234_5678);
    check({31'h0, irq}, 32'h0000_0000);
    set_ready(1'b0);
    set_ready(1'b1);
    check({31'h0, irq}, 32'h0000_0001);
    cpu.wr_reg(CTRL_ADDR, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    set_ready(1'b0);
  endtask : s_aux

  task automatic s_hpd();
    cpu.wr_reg(CTRL_ADDR, 32'h8000_0000);
    hpd_pulse(1'b1, 1'b0);
    check({31'h0, irq}, 32'h0000_0001);
    cpu.rd_reg(STAT_ADDR, r);
    check(r, 32'h0000_0005);
    check({31'h0, irq}, 32'h0000_0000);
    cpu.rd_reg(STAT_ADDR, r);
    check(r, 32'h0000_0004);
    hpd_pulse(1'b0, 1'b1);
    cpu.rd_reg(STAT_ADDR, r);
    check(r, 32'h0000_0006);
    hpd_pulse(1'b1, 1'b1);
    cpu.rd_reg(STAT_ADDR, r);
    check(r, 32'h0000_0005);
    @(posedge ref_clk_i);
    level <= 1'b0;
    cpu.rd_reg(STAT_ADDR, r);
    check(r, 32'h0000_0000);
    cpu.wr_reg(CTRL_ADDR, 32'h0000_0000);
  endtask : s_hpd

  task automatic s_intr();
    cpu.wr_reg(ISTAT_ADDR, 32'h0000_0003);
    cpu.wr_reg(IMASK_ADDR, 32'h0000_0002);
    cpu.rd_reg(IMASK_ADDR, r);
    check(r, 32'h0000_0002);
    hpd_pulse(1'b0, 1'b1);
    check({31'h0, irq}, 32'h0000_0001);
    cpu.rd_reg(ISTAT_ADDR, r);
    check(r, 32'h0000_0002);
    cpu.wr_reg(ISTAT_ADDR, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0000);
    cpu.wr_reg(IMASK_ADDR, 32'h0000_0000);
    hpd_pulse(1'b1, 1'b0);
    check({31'h0, irq}, 32'h0000_0000);
    cpu.rd_reg(ISTAT_ADDR, r);
    check(r, 32'h0000_0002);
  endtask : s_intr

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    ready = 1'b0;
    level = 1'b1;
    ev_long = 1'b0;
    ev_short = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    s_reset();
    s_fields();
    s_aux();
    s_hpd();
    s_intr();
    give_verdict();
  end
endmodule : tb
